// ===== hw/sorc_regs.sv
// The register offsets and register access over APB were left to the implementer.
`timescale 1ns/100ps
module sorc_regs (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        frame_check_fault,
  input  wire logic        watchdog_expired_flag,
  input  wire logic        current_load_fault,
  input  wire logic        slewing_active,
  input  wire logic        over_temperature_flag,
  input  wire logic        clear_value_select_pin,
  output logic      [15:0] conversion_code,
  output logic      [2:0]  voltage_range,
  output logic      [1:0]  current_range,
  output logic             voltage_output_enable,
  output logic             current_output_enable,
  output logic             alternate_power_down,
  output logic             irq
);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [2:0]  range;
    logic        clear_value_select_bit;
    logic [1:0]  current_range_field;
    logic        both_outputs_enable;
    logic        alt_power_down;
    logic [15:0] data;
    logic [4:0]  events;
    logic [4:0]  mask;
    logic [4:0]  flags_q;
    logic [31:0] rdata;
    logic        err;
  } sorc_regs_s;

  sorc_regs_s st;
  sorc_regs_s next_st;

  logic [4:0] flags;
  logic [4:0] raw_flags;
  logic       setup;
  logic       access;
  logic       do_write;
  logic       do_read;
  logic       soft_reset;

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  function automatic logic is_current(input logic [2:0] r);
    is_current = r[2] && (r != sorc_pkg::RANGE_OFF);
  endfunction

  function automatic logic is_voltage(input logic [2:0] r);
    is_voltage = !r[2];
  endfunction

  // Bipolar voltage ranges clear to 0 V, which is midscale code, so
  // the select only matters for unipolar voltage ranges and RANGE_OFF.
  function automatic logic [15:0] clear_code(input logic [2:0] r,
                                             input logic       sel);
    if (is_current(r)) begin
      clear_code = sorc_pkg::CODE_ZERO;
    end else if (sel || r == sorc_pkg::RANGE_BIP5 ||
                 r == sorc_pkg::RANGE_BIP10) begin
      clear_code = sorc_pkg::CODE_MID;
    end else begin
      clear_code = sorc_pkg::CODE_ZERO;
    end
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    case (a)
      sorc_pkg::OFF_STATUS,
      sorc_pkg::OFF_CONTROL,
      sorc_pkg::OFF_CONFIG,
      sorc_pkg::OFF_DATA,
      sorc_pkg::OFF_EVENTS,
      sorc_pkg::OFF_MASK,
      sorc_pkg::OFF_SOFT_RST: mapped = 1'b1;
      default:                mapped = 1'b0;
    endcase
  endfunction

  // ------------------------------------------------------------------
  // Flag sampling
  // ------------------------------------------------------------------
  always_comb begin
    raw_flags = '0;
    raw_flags[sorc_pkg::BIT_FRAME]    = frame_check_fault;
    raw_flags[sorc_pkg::BIT_WATCHDOG] = watchdog_expired_flag;
    raw_flags[sorc_pkg::BIT_LOAD]     = current_load_fault;
    raw_flags[sorc_pkg::BIT_SLEW]     = slewing_active;
    raw_flags[sorc_pkg::BIT_TEMP]     = over_temperature_flag;
  end

  sorc_flag_sample #(
    .WIDTH (sorc_pkg::FLAG_W)
  ) u_sample (
    .pclk       (pclk),
    .presetn    (presetn),
    .soft_clear (soft_reset),
    .raw_flags  (raw_flags),
    .flags      (flags)
  );

  // ------------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------------
  assign setup    = psel && !penable;
  assign access   = psel && penable;
  assign do_write = access && pwrite && mapped(paddr);
  assign do_read  = access && !pwrite && mapped(paddr);
  assign soft_reset = do_write && paddr == sorc_pkg::OFF_SOFT_RST &&
                      pwdata[sorc_pkg::RST_BIT];

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.flags_q = flags;
    if (setup) begin
      next_st.err   = !mapped(paddr);
      next_st.rdata = '0;
      case (paddr)
        sorc_pkg::OFF_STATUS: begin
          next_st.rdata[4:0] = flags;
        end
        sorc_pkg::OFF_CONTROL: begin
          next_st.rdata[2:0] = st.range;
          next_st.rdata[sorc_pkg::CTL_CLEAR_SEL] =
            st.clear_value_select_bit;
        end
        sorc_pkg::OFF_CONFIG: begin
          next_st.rdata[sorc_pkg::CFG_CUR_LSB +: 2] =
            st.current_range_field;
          next_st.rdata[sorc_pkg::CFG_DUAL] = st.both_outputs_enable;
          next_st.rdata[sorc_pkg::CFG_ALT_PD] = st.alt_power_down;
        end
        sorc_pkg::OFF_DATA:   next_st.rdata[15:0] = st.data;
        sorc_pkg::OFF_EVENTS: next_st.rdata[4:0]  = st.events;
        sorc_pkg::OFF_MASK:   next_st.rdata[4:0]  = st.mask;
        default:              next_st.rdata = '0;
      endcase
    end
    // Read clears the events; a new event in the same cycle survives.
    if (do_read && paddr == sorc_pkg::OFF_EVENTS) begin
      next_st.events = '0;
    end
    if (do_write) begin
      case (paddr)
        sorc_pkg::OFF_CONTROL: begin
          next_st.range = pwdata[sorc_pkg::CTL_RANGE_LSB +: 3];
          next_st.clear_value_select_bit = pwdata[sorc_pkg::CTL_CLEAR_SEL];
          if (pwdata[sorc_pkg::CTL_RANGE_LSB +: 3] != st.range) begin
            next_st.data = clear_code(
              pwdata[sorc_pkg::CTL_RANGE_LSB +: 3],
              pwdata[sorc_pkg::CTL_CLEAR_SEL] ||
              clear_value_select_pin);
          end
        end
        sorc_pkg::OFF_CONFIG: begin
          next_st.current_range_field =
            pwdata[sorc_pkg::CFG_CUR_LSB +: 2];
          next_st.both_outputs_enable = pwdata[sorc_pkg::CFG_DUAL];
          next_st.alt_power_down = pwdata[sorc_pkg::CFG_ALT_PD];
        end
        sorc_pkg::OFF_DATA: begin
          next_st.data = pwdata[15:0];
        end
        sorc_pkg::OFF_MASK: begin
          next_st.mask = pwdata[4:0];
        end
        default: begin
        end
      endcase
    end
    next_st.events = next_st.events | (flags & ~st.flags_q);
    if (soft_reset) begin
      next_st.range                  = sorc_pkg::RANGE_RESET;
      next_st.clear_value_select_bit = 1'b0;
      next_st.current_range_field    = sorc_pkg::CUR_RESET;
      next_st.both_outputs_enable    = 1'b0;
      next_st.alt_power_down         = 1'b0;
      next_st.data                   = sorc_pkg::DATA_RESET;
      next_st.events                 = '0;
      next_st.mask                   = sorc_pkg::MASK_RESET;
      next_st.flags_q                = '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st.range                  <= sorc_pkg::RANGE_RESET;
      st.clear_value_select_bit <= 1'b0;
      st.current_range_field    <= sorc_pkg::CUR_RESET;
      st.both_outputs_enable    <= 1'b0;
      st.alt_power_down         <= 1'b0;
      st.data                   <= sorc_pkg::DATA_RESET;
      st.events                 <= '0;
      st.mask                   <= sorc_pkg::MASK_RESET;
      st.flags_q                <= '0;
      st.rdata                  <= '0;
      st.err                    <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  // Without the dual bit the range field alone picks one output; a
  // host that breaks this only loses the second output, never the code.
  assign voltage_range = st.range;
  assign current_range = st.both_outputs_enable ?
                         st.current_range_field :
                         st.range[1:0];
  assign voltage_output_enable = is_voltage(st.range);
  assign current_output_enable = st.both_outputs_enable ||
                                 is_current(st.range);
  assign conversion_code = st.data;
  assign alternate_power_down = st.alt_power_down;
  assign irq     = |(st.events & st.mask);
  assign prdata  = st.rdata;
  assign pready  = 1'b1;
  assign pslverr = access && st.err;

endmodule

// ===== hw/sorc_pkg.sv
package sorc_pkg;

  // ------------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------------
  localparam logic [7:0] OFF_STATUS   = 8'h00;
  localparam logic [7:0] OFF_CONTROL  = 8'h04;
  localparam logic [7:0] OFF_CONFIG   = 8'h08;
  localparam logic [7:0] OFF_DATA     = 8'h0c;
  localparam logic [7:0] OFF_EVENTS   = 8'h10;
  localparam logic [7:0] OFF_MASK     = 8'h14;
  localparam logic [7:0] OFF_SOFT_RST = 8'h18;

  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int FLAG_W        = 5;
  localparam int BIT_FRAME     = 4;
  localparam int BIT_WATCHDOG  = 3;
  localparam int BIT_LOAD      = 2;
  localparam int BIT_SLEW      = 1;
  localparam int BIT_TEMP      = 0;
  localparam int CTL_RANGE_LSB = 0;
  localparam int CTL_CLEAR_SEL = 3;
  localparam int CFG_CUR_LSB   = 9;
  localparam int CFG_DUAL      = 8;
  localparam int CFG_ALT_PD    = 6;
  localparam int RST_BIT       = 0;

  // ------------------------------------------------------------------
  // Reset values and codes
  // ------------------------------------------------------------------
  localparam logic [2:0]  RANGE_RESET  = 3'h0;
  localparam logic [1:0]  CUR_RESET    = 2'h0;
  localparam logic [15:0] DATA_RESET   = 16'h0000;
  localparam logic [15:0] CODE_ZERO    = 16'h0000;
  localparam logic [15:0] CODE_MID     = 16'h8000;
  localparam logic [4:0]  MASK_RESET   = 5'h00;
  localparam logic [2:0]  RANGE_OFF    = 3'h4;
  localparam logic [2:0]  RANGE_BIP5   = 3'h2;
  localparam logic [2:0]  RANGE_BIP10  = 3'h3;

endpackage

// ===== hw/sorc_flag_sample.sv
`timescale 1ns/100ps
module sorc_flag_sample #(
  parameter int WIDTH = 5
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             soft_clear,
  input  wire logic [WIDTH-1:0] raw_flags,
  output logic      [WIDTH-1:0] flags
);

  typedef struct packed {
    logic [WIDTH-1:0] snap;
  } sorc_samp_s;

  sorc_samp_s st;
  sorc_samp_s next_st;

  // A reset drops the snapshot for one cycle; a cause still present
  // comes back on the following edge.
  always_comb begin
    next_st = st;
    if (soft_clear) begin
      next_st.snap = '0;
    end else begin
      next_st.snap = raw_flags;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign flags = st.snap;

endmodule

// ===== testbench/sorc_regs_properties.sv
`timescale 1ns/100ps
module sorc_regs_properties (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        clear_value_select_pin,
  input wire logic [15:0] conversion_code,
  input wire logic [2:0]  voltage_range,
  input wire logic [1:0]  current_range,
  input wire logic        voltage_output_enable,
  input wire logic        current_output_enable,
  input wire logic        alternate_power_down
);
  logic [15:0] clr;
  logic        wr;
  logic        rd;
  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  // Current ranges always clear to zero, whatever the select says.
  assign clr = (pwdata[2:0] < 3'h5 && (pwdata[1] || pwdata[3] ||
               clear_value_select_pin)) ? 16'h8000 : 16'h0000;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_reserved; rd && paddr == 8'h00 |-> prdata[31:5] == 27'h0;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("Status top bits not zero.");
  property p_clear; wr && paddr == 8'h04 && pwdata[2:0] != voltage_range
    |=> conversion_code == $past(clr); endproperty
  a_clear: assert property (p_clear)
    else $error("Range change gave wrong clear code.");
  property p_keep; wr && paddr == 8'h04 && pwdata[2:0] == voltage_range
    |=> $stable(conversion_code); endproperty
  a_keep: assert property (p_keep)
    else $error("Same range changed the code.");
  property p_code; wr && paddr == 8'h0c
    |=> {16'h0, conversion_code} == ($past(pwdata) & 32'hffff); endproperty
  a_code: assert property (p_code)
    else $error("Code register not loaded.");
  property p_dual; wr && paddr == 8'h08 && pwdata[8] |=> current_output_enable
    && {30'h0, current_range} == (($past(pwdata) >> 9) & 32'h3); endproperty
  a_dual: assert property (p_dual)
    else $error("Dual current range wrong.");
  property p_joined; wr && paddr == 8'h08 && !pwdata[8]
    |=> current_range == voltage_range[1:0]; endproperty
  a_joined: assert property (p_joined)
    else $error("Single mode current range wrong.");
  property p_apd; wr && paddr == 8'h08
    |=> {25'h0, alternate_power_down, 6'h0} == ($past(pwdata) & 32'h40);
  endproperty
  a_apd: assert property (p_apd)
    else $error("Power-down bit not followed.");
  property p_enables; voltage_output_enable == !voltage_range[2]
    && (current_output_enable || voltage_range < 3'h5); endproperty
  a_enables: assert property (p_enables)
    else $error("Output enables do not follow range.");
endmodule
bind sorc_regs sorc_regs_properties sorc_regs_properties_i (.*);

// ===== testbench/sorc_flag_source.sv
`timescale 1ns/100ps
module sorc_flag_source (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [4:0] cause,
  output logic            frame_check_fault,
  output logic            watchdog_expired_flag,
  output logic            current_load_fault,
  output logic            slewing_active,
  output logic            over_temperature_flag
);
  logic [4:0] q;
  assign {frame_check_fault, watchdog_expired_flag, current_load_fault,
          slewing_active, over_temperature_flag} = q;
  // Monitors launch from pclk, so the block never sees a half-cycle pulse.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= 5'h00;
    end else begin
      q <= cause;
    end
  end
endmodule

// ===== testbench/sorc_regs_tb.sv
`timescale 1ns/100ps
module sorc_regs_tb;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        clear_value_select_pin = 1'b0;
  logic [4:0]  cause = 5'h00;
  logic        pready, pslverr, err, irq, alternate_power_down;
  logic        voltage_output_enable, current_output_enable;
  logic        frame_check_fault, watchdog_expired_flag, current_load_fault;
  logic        slewing_active, over_temperature_flag;
  logic [15:0] conversion_code;
  logic [2:0]  voltage_range;
  logic [1:0]  current_range;
  logic [3:0]  tbl_ctl [7] = '{4'h3, 4'h3, 4'h5, 4'h4, 4'h9, 4'h0, 4'h1};
  logic        tbl_pin [7] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
  logic [15:0] tbl_code [7] = '{16'h8000, 16'h1234, 16'h0000, 16'h0000,
                                16'h8000, 16'h8000, 16'h0000};
  int          num_errors = 0;
  int          compares = 0;

  always #50 pclk = ~pclk;
  sorc_regs sorc_regs_i (.*);
  sorc_flag_source sorc_flag_source_i (.*);

  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // The answer is taken at the rising edge that sees pready high, so any
  // number of wait states is followed; only the watchdog ends a hang.
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic conclude;
    $display("Compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // The tests take well under a thousand cycles.
  initial begin
    #1000000;
    num_errors++;
    conclude();
  end

  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0);
      chk("reset value", rd, 32'h0);
    end
    $display("Test reset done");
    apb(1'b1, 8'h14, 32'h1f);
    for (int i = 0; i < 5; i++) begin
      cause <= 5'h01 << i;
      repeat (3) @(posedge pclk);
      apb(1'b0, 8'h00, 32'h0);
      chk("status", rd, 32'h1 << i);
      chk("irq", 32'(irq), 32'h1);
      apb(1'b0, 8'h10, 32'h0);
      @(posedge pclk);
      chk("event", rd, 32'h1 << i);
      chk("irq cleared", 32'(irq), 32'h0);
      cause <= 5'h00;
      repeat (3) @(posedge pclk);
      apb(1'b0, 8'h00, 32'h0);
      chk("status gone", rd, 32'h0);
    end
    apb(1'b1, 8'h14, 32'h0);
    cause <= 5'h02;
    repeat (3) @(posedge pclk);
    chk("masked irq", 32'(irq), 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    chk("masked event", rd, 32'h2);
    $display("Test flags done");
    // Configuration stays 0000 in bits 10 to 7 here.
    for (int i = 0; i < 7; i++) begin
      apb(1'b1, 8'h0c, 32'h1234);
      clear_value_select_pin <= tbl_pin[i];
      apb(1'b1, 8'h04, 32'(tbl_ctl[i]));
      apb(1'b0, 8'h04, 32'h0);
      chk("control", rd, 32'(tbl_ctl[i]));
      chk("clear code", 32'(conversion_code), 32'(tbl_code[i]));
      chk("voltage range", 32'(voltage_range), 32'(tbl_ctl[i][2:0]));
      chk("voltage on", 32'(voltage_output_enable), 32'(!tbl_ctl[i][2]));
      chk("current on", 32'(current_output_enable),
          32'(tbl_ctl[i][2:0] > 3'h4));
    end
    $display("Test ranges done");
    apb(1'b1, 8'h08, 32'h740);
    apb(1'b1, 8'h0c, 32'habcd);
    @(negedge pclk);
    chk("dual", 32'({current_range, current_output_enable,
        voltage_output_enable, alternate_power_down}), 32'h1f);
    chk("shared code", 32'(conversion_code), 32'habcd);
    apb(1'b0, 8'h08, 32'h0);
    chk("config", rd, 32'h740);
    apb(1'b1, 8'h08, 32'h0);
    @(negedge pclk);
    chk("single", 32'({current_range, current_output_enable}), 32'h2);
    $display("Test dual done");
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped err", 32'(err), 32'h1);
    chk("unmapped data", rd, 32'h0);
    apb(1'b1, 8'h00, 32'hffff);
    apb(1'b0, 8'h00, 32'h0);
    chk("status ro", rd, 32'h2);
    apb(1'b1, 8'h18, 32'h1);
    repeat (3) @(posedge pclk);
    apb(1'b0, 8'h00, 32'h0);
    chk("flag again", rd, 32'h2);
    apb(1'b0, 8'h04, 32'h0);
    chk("soft reset", rd, 32'h0);
    $display("Test refusal and soft reset done");
    conclude();
  end
endmodule
